/* File: rtl/tc8_pkg.sv */
// Constants and types shared by the 8-bit timer/counter core
`default_nettype none
package tc8_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_FLAG = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // Counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  // Flag and mask bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP = 1;
  // Status bit positions
  localparam int ST_BOTTOM = 0;
  localparam int ST_MAX = 1;
  localparam int ST_TOP = 2;
  localparam int ST_DIR_UP = 3;
  // Prescaler width and tap masks
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_DIV8 = 10'h007;
  localparam logic [9:0] PRE_DIV64 = 10'h03f;
  localparam logic [9:0] PRE_DIV256 = 10'h0ff;
  localparam logic [9:0] PRE_DIV1024 = 10'h3ff;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Waveform mode codes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PC_PWM = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;
  // Control register layout: mode bits [4:3], clock select [2:0]
  typedef struct packed {
    logic [1:0] waveform_mode_field;
    logic [2:0] clock_select_field;
  } ctrl_s;
  localparam ctrl_s RST_CTRL = '{waveform_mode_field: 2'h0, clock_select_field: 3'h0};
endpackage : tc8_pkg
`default_nettype wire

/* File: rtl/timer_counter_core_8bit.sv */
// 8-bit timer/counter core with one compare channel and an AHB-Lite register slave
// Operation
// - Counter and compare value are 8-bit registers, CPU readable and writable.
// - Bottom is signalled whenever the counter value is zero.
// - All-ones value 255 is the counter maximum.
// - Top is the maximum or the compare value, chosen by mode.
// - Counter is clocked by the prescaled clock or the external count pin.
// - Clock select picks source and edge; its output is the timer tick.
// - Clock select zero gives no tick; the counter stops.
// - Each tick clears, increments or decrements the counter as the mode dictates.
// - CPU may read and write the counter at any time.
// - A CPU counter write beats any clear or count in that cycle.
// - Two waveform mode bits in the control register select the count sequence.
// - Overflow flag sets at the mode's point and can request an interrupt.
// - Active compare value is compared with the counter every cycle.
// - Each compare match on a tick not blocked by a counter write sets the compare flag, which can request an interrupt.
// - All requests show in the flag register, each gated by its mask bit.
// - Compare result drives the waveform generator onto the compare output pin.
// - Compare value is double buffered in PWM modes: CPU buffer apart from comparator value.
// - Compare flag sets one tick after match; clears on acknowledge or written one.
// - A CPU counter write blocks compare matches on the next tick, even stopped.
// - Normal mode counts up, wraps max to zero, sets overflow reaching zero.
// - Clear-on-compare mode resets the counter at the compare value, its top.
`timescale 1ns/10ps
`default_nettype none
module timer_counter_core_8bit (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External count pin and interrupt acknowledges
  input wire logic external_count_pin,
  input wire logic ovf_ack,
  input wire logic cmp_ack,
  // Interrupt requests and compare output
  output logic ovf_irq,
  output logic cmp_irq,
  output logic compare_output_pin
);
  import tc8_pkg::*;

  // Bus state
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ready_r;
  // Timer state
  tc8_pkg::ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0] count_value_r, count_value_nxt;
  logic [7:0] cmp_buf_r, cmp_buf_nxt;
  logic [7:0] cmp_act_r, cmp_act_nxt;
  logic [1:0] timer_flag_r, timer_flag_nxt;
  logic [1:0] timer_mask_r, timer_mask_nxt;
  logic dir_up_r, dir_up_nxt;
  logic block_r, block_nxt;
  logic pin_r, pin_nxt;
  logic ovf_irq_r, cmp_irq_r;
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  // Decoded strobes
  logic cnt_wr, ctrl_wr, cmp_wr, flag_wr, mask_wr;
  logic tick, pwm_mode, at_max, at_bottom, at_top, match, ovf_set, cmp_set;
  logic [7:0] top_val;
  logic [7:0] wbyte;

  // External pin: two-stage synchroniser, third stage for edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Bus address phase capture and read data
  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (hsel && hready && htrans[1]) begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = haddr[7:0];
      rdata_nxt = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[7:0] == OFF_CONTROL) begin
          rdata_nxt = {27'h000_0000, ctrl_r};
        end else if (haddr[7:0] == OFF_COUNT) begin
          rdata_nxt = {24'h00_0000, count_value_r};
        end else if (haddr[7:0] == OFF_COMPARE) begin
          rdata_nxt = {24'h00_0000, cmp_buf_r};
        end else if (haddr[7:0] == OFF_FLAG) begin
          rdata_nxt = {30'h0000_0000, timer_flag_r};
        end else if (haddr[7:0] == OFF_MASK) begin
          rdata_nxt = {30'h0000_0000, timer_mask_r};
        end else if (haddr[7:0] == OFF_STATUS) begin
          rdata_nxt = {28'h000_0000, dir_up_r, at_top, at_max, at_bottom};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= RST_BYTE;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= 1'b1;
    end
  end

  // Data phase write strobes
  assign wbyte = hwdata[7:0];
  assign ctrl_wr = wr_pend_r && (wr_addr_r == OFF_CONTROL);
  assign cnt_wr = wr_pend_r && (wr_addr_r == OFF_COUNT);
  assign cmp_wr = wr_pend_r && (wr_addr_r == OFF_COMPARE);
  assign flag_wr = wr_pend_r && (wr_addr_r == OFF_FLAG);
  assign mask_wr = wr_pend_r && (wr_addr_r == OFF_MASK);

  // Clock select: source and edge form the timer tick
  always_comb begin
    case (ctrl_r.clock_select_field)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = ((pre_r & PRE_DIV8) == PRE_DIV8);
      CS_DIV64: tick = ((pre_r & PRE_DIV64) == PRE_DIV64);
      CS_DIV256: tick = ((pre_r & PRE_DIV256) == PRE_DIV256);
      CS_DIV1024: tick = (pre_r == PRE_DIV1024);
      CS_EXT_FALL: tick = ext_s3_r && !ext_s2_r;
      CS_EXT_RISE: tick = !ext_s3_r && ext_s2_r;
      default: tick = 1'b0;
    endcase
  end

  // Limits, top and continuous compare
  assign pwm_mode = ctrl_r.waveform_mode_field[0];
  assign top_val = (ctrl_r.waveform_mode_field == WGM_CTC) ? cmp_act_r : CNT_MAX;
  assign at_bottom = (count_value_r == CNT_BOTTOM);
  assign at_max = (count_value_r == CNT_MAX);
  assign at_top = (count_value_r == top_val);
  assign match = (count_value_r == cmp_act_r);
  assign cmp_set = tick && match && !block_r;
  assign ovf_set = tick && (ctrl_r.waveform_mode_field == WGM_PC_PWM ? (at_bottom && !dir_up_r) : at_max);

  // Timer next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    count_value_nxt = count_value_r;
    cmp_buf_nxt = cmp_buf_r;
    cmp_act_nxt = cmp_act_r;
    timer_mask_nxt = timer_mask_r;
    dir_up_nxt = dir_up_r;
    block_nxt = block_r;
    pin_nxt = pin_r;
    pre_nxt = pre_r + 10'h001;
    // Counting per mode
    if (tick) begin
      block_nxt = 1'b0;
      case (ctrl_r.waveform_mode_field)
        WGM_CTC: begin
          count_value_nxt = at_top ? CNT_BOTTOM : count_value_r + 8'h01;
        end
        WGM_PC_PWM: begin
          if (dir_up_r) begin
            dir_up_nxt = !at_max;
            count_value_nxt = at_max ? count_value_r - 8'h01 : count_value_r + 8'h01;
          end else begin
            dir_up_nxt = at_bottom;
            count_value_nxt = at_bottom ? count_value_r + 8'h01 : count_value_r - 8'h01;
          end
        end
        default: begin
          count_value_nxt = count_value_r + 8'h01;
          dir_up_nxt = 1'b1;
        end
      endcase
      // Buffered compare value loads at the limit in PWM modes
      if (pwm_mode && at_max) begin
        cmp_act_nxt = cmp_buf_r;
      end
      // Waveform generator
      if (ctrl_r.waveform_mode_field == WGM_FAST_PWM && at_max) begin
        pin_nxt = 1'b1;
      end
    end
    if (cmp_set) begin
      if (!pwm_mode) begin
        pin_nxt = !pin_r;
      end else if (ctrl_r.waveform_mode_field == WGM_FAST_PWM) begin
        pin_nxt = 1'b0;
      end else begin
        pin_nxt = !dir_up_r;
      end
    end
    // CPU writes win over counting
    if (cnt_wr) begin
      count_value_nxt = wbyte;
      block_nxt = 1'b1;
    end
    if (ctrl_wr) begin
      ctrl_nxt = ctrl_s'(wbyte[4:0]);
    end
    if (cmp_wr) begin
      cmp_buf_nxt = wbyte;
      if (!pwm_mode) begin
        cmp_act_nxt = wbyte;
      end
    end
    if (mask_wr) begin
      timer_mask_nxt = wbyte[1:0];
    end
    // Flags: set beats written-one or acknowledge clear
    timer_flag_nxt = timer_flag_r;
    if (flag_wr) begin
      timer_flag_nxt = timer_flag_nxt & ~wbyte[1:0];
    end
    if (ovf_ack) begin
      timer_flag_nxt[FLAG_OVF] = 1'b0;
    end
    if (cmp_ack) begin
      timer_flag_nxt[FLAG_CMP] = 1'b0;
    end
    if (ovf_set) begin
      timer_flag_nxt[FLAG_OVF] = 1'b1;
    end
    if (cmp_set) begin
      timer_flag_nxt[FLAG_CMP] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= RST_CTRL;
      count_value_r <= RST_BYTE;
      cmp_buf_r <= RST_BYTE;
      cmp_act_r <= RST_BYTE;
      timer_flag_r <= RST_FLAGS;
      timer_mask_r <= RST_FLAGS;
      dir_up_r <= 1'b1;
      block_r <= 1'b0;
      pin_r <= 1'b0;
      pre_r <= '0;
      ovf_irq_r <= 1'b0;
      cmp_irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_value_r <= count_value_nxt;
      cmp_buf_r <= cmp_buf_nxt;
      cmp_act_r <= cmp_act_nxt;
      timer_flag_r <= timer_flag_nxt;
      timer_mask_r <= timer_mask_nxt;
      dir_up_r <= dir_up_nxt;
      block_r <= block_nxt;
      pin_r <= pin_nxt;
      pre_r <= pre_nxt;
      ovf_irq_r <= timer_flag_r[FLAG_OVF] && timer_mask_r[FLAG_OVF];
      cmp_irq_r <= timer_flag_r[FLAG_CMP] && timer_mask_r[FLAG_CMP];
    end
  end

  // Outputs
  assign hrdata = rdata_r;
  assign hreadyout = ready_r;
  assign hresp = 1'b0;
  assign ovf_irq = ovf_irq_r;
  assign cmp_irq = cmp_irq_r;
  assign compare_output_pin = pin_r;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cpu_write_wins: assert property (cnt_wr |=> count_value_r == $past(wbyte))
    else $error("counter write lost");
  a_stopped_holds: assert property ((ctrl_r.clock_select_field == CS_STOP && !cnt_wr) |=> $stable(count_value_r))
    else $error("stopped counter moved");
  a_stop_no_flags: assert property ((ctrl_r.clock_select_field == CS_STOP && timer_flag_r == 2'h0) |=> timer_flag_r == 2'h0)
    else $error("flag set without tick");
  a_normal_wrap: assert property ((tick && !cnt_wr && at_max && ctrl_r.waveform_mode_field == WGM_NORMAL)
    |=> (count_value_r == CNT_BOTTOM) && timer_flag_r[FLAG_OVF])
    else $error("normal mode wrap wrong");
  a_ctc_clear: assert property ((tick && !cnt_wr && ctrl_r.waveform_mode_field == WGM_CTC && match)
    |=> count_value_r == CNT_BOTTOM)
    else $error("compare clear missed");
  a_match_flag: assert property ((tick && match && !block_r) |=> timer_flag_r[FLAG_CMP])
    else $error("compare flag not set");
  a_write_blocks: assert property ((tick && block_r && !timer_flag_r[FLAG_CMP]) |=> !timer_flag_r[FLAG_CMP])
    else $error("blocked match set flag");
  a_mask_gates: assert property (!timer_mask_r[FLAG_OVF] |=> !ovf_irq)
    else $error("masked overflow request");
  a_irq_follows: assert property ((timer_flag_r[FLAG_CMP] && timer_mask_r[FLAG_CMP]) |=> cmp_irq)
    else $error("compare request missing");
endmodule : timer_counter_core_8bit
`default_nettype wire

/* File: sim/ext_event_src.sv */
// External event source that drives the timer's count input pin
`timescale 1ns/10ps
`default_nettype none
module ext_event_src (
  // Clock
  input wire logic hclk,
  // Event pin, idles low
  output logic external_count_pin
);
  initial external_count_pin = 1'b0;
  // Each event is long enough on both levels for the two-stage synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      external_count_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      external_count_pin <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask : pulses
endmodule : ext_event_src
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking testbench for the 8-bit timer/counter core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tc8_pkg::*;
  logic hclk, hresetn, hsel, hwrite, ovf_ack, cmp_ack, ext_pin, hreadyout, hresp, ovf_irq, cmp_irq, cop;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [1:0] ef;
  logic [7:0] offs [7];
  int failures, checked, ec, ecmp, emode, rv [7];
  bit blk, epin;
  timer_counter_core_8bit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_count_pin(ext_pin), .ovf_ack(ovf_ack), .cmp_ack(cmp_ack), .ovf_irq(ovf_irq),
    .cmp_irq(cmp_irq), .compare_output_pin(cop));
  ext_event_src u_src (.hclk(hclk), .external_count_pin(ext_pin));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Watchdog
  initial begin
    #800000;
    failures++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wcnt(input logic [7:0] v);
    bus(OFF_COUNT, 1'b1, v);
    ec = int'(v);
    blk = 1'b1;
  endtask : wcnt
  task automatic wcmp(input logic [7:0] v);
    bus(OFF_COMPARE, 1'b1, v);
    ecmp = int'(v);
  endtask : wcmp
  task automatic wctl(input logic [1:0] m, input logic [2:0] cs);
    bus(OFF_CONTROL, 1'b1, {3'h0, m, cs});
    emode = int'(m);
  endtask : wctl
  // Events on the pin, mirrored by the reference counter, then compared
  task automatic ticks(input int n);
    u_src.pulses(n);
    repeat (n) begin
      if (!blk && ec == ecmp) begin
        ef[1] = 1'b1;
        epin = ~epin;
      end
      blk = 1'b0;
      if (ec == 255) ef[0] = 1'b1;
      ec = (emode == 2 && ec == ecmp) ? 0 : (ec + 1) % 256;
    end
    bus(OFF_COUNT, 1'b0, 8'h00);
    check(rd, 32'(ec));
    bus(OFF_FLAG, 1'b0, 8'h00);
    check(rd, {30'h0, ef});
    check({31'h0, cop}, {31'h0, epin});
  endtask : ticks
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, ovf_ack, cmp_ack, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    seed = 32'd66638;
    {ec, ecmp, emode, ef, blk, epin} = '0;
    offs = '{OFF_CONTROL, OFF_COUNT, OFF_COMPARE, OFF_FLAG, OFF_MASK, OFF_STATUS, 8'h18};
    rv = '{0, 0, 0, 0, 0, 9, 0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (offs[i]) begin
      bus(offs[i], 1'b0, 8'h00);
      check(rd, 32'(rv[i]));
      check({31'h0, hresp}, 32'h0);
    end
    repeat (4) begin
      seed = xs(seed);
      wcnt(seed[7:0]);
      bus(OFF_COUNT, 1'b0, 8'h00);
      check(rd, 32'(ec));
      wcmp(seed[15:8]);
      bus(OFF_COMPARE, 1'b0, 8'h00);
      check(rd, 32'(ecmp));
    end
    // Stopped timer ignores the pin
    u_src.pulses(2);
    bus(OFF_COUNT, 1'b0, 8'h00);
    check(rd, 32'(ec));
    wcnt(8'hff);
    bus(OFF_STATUS, 1'b0, 8'h00);
    check(rd, 32'h0000000e);
    // Normal mode wrap, overflow flag and its request
    wcmp(8'h80);
    wctl(2'h0, CS_EXT_RISE);
    wcnt(8'hfd);
    ticks(3);
    bus(OFF_MASK, 1'b1, 8'h01);
    repeat (2) @(negedge hclk);
    check({31'h0, ovf_irq}, 32'h1);
    bus(OFF_FLAG, 1'b1, 8'h01);
    ef[0] = 1'b0;
    repeat (2) @(negedge hclk);
    check({31'h0, ovf_irq}, 32'h0);
    // Compare flag one tick after the match
    wcmp(8'h05);
    wcnt(8'h03);
    ticks(2);
    ticks(1);
    bus(OFF_MASK, 1'b1, 8'h02);
    repeat (2) @(negedge hclk);
    check({31'h0, cmp_irq}, 32'h1);
    @(posedge hclk);
    cmp_ack <= 1'b1;
    @(posedge hclk);
    cmp_ack <= 1'b0;
    ef[1] = 1'b0;
    bus(OFF_FLAG, 1'b0, 8'h00);
    check(rd, {30'h0, ef});
    // Counter write while stopped blocks the next match
    wctl(2'h0, CS_STOP);
    wcnt(8'h05);
    wctl(2'h0, CS_EXT_RISE);
    ticks(1);
    // Clear-on-compare on falling edges
    wctl(2'h2, CS_EXT_FALL);
    wcmp(8'h04);
    wcnt(8'h00);
    ticks(5);
    wcnt(8'h04);
    bus(OFF_STATUS, 1'b0, 8'h00);
    check(rd, 32'h0000000c);
    // Fast PWM keeps the old active compare until the tick at max
    wctl(2'h3, CS_EXT_RISE);
    wcmp(8'h03);
    bus(OFF_FLAG, 1'b1, 8'h03);
    wcnt(8'h02);
    u_src.pulses(2);
    bus(OFF_COUNT, 1'b0, 8'h00);
    check(rd, 32'h0000_0004);
    bus(OFF_FLAG, 1'b0, 8'h00);
    check(rd, 32'h0000_0000);
    wcnt(8'hff);
    u_src.pulses(1);
    check({31'h0, cop}, 32'h1);
    bus(OFF_FLAG, 1'b0, 8'h00);
    check(rd, 32'h0000_0001);
    u_src.pulses(4);
    bus(OFF_FLAG, 1'b0, 8'h00);
    check(rd, 32'h0000_0003);
    check({31'h0, cop}, 32'h0);
    // Phase correct turns at max and counts down
    wctl(2'h1, CS_EXT_RISE);
    wcnt(8'hfe);
    u_src.pulses(3);
    bus(OFF_COUNT, 1'b0, 8'h00);
    check(rd, 32'h0000_00fd);
    bus(OFF_STATUS, 1'b0, 8'h00);
    check(rd, 32'h0000_0000);
    // Every internal clock select moves the counter
    for (int cs = 1; cs < 6; cs++) begin
      wcnt(8'h00);
      wctl(2'h0, 3'(cs));
      repeat (1100) @(posedge hclk);
      wctl(2'h0, CS_STOP);
      bus(OFF_COUNT, 1'b0, 8'h00);
      check({31'h0, rd[7:0] != 8'h00}, 32'h1);
    end
    // Overflow flag cleared by its interrupt acknowledge
    bus(OFF_FLAG, 1'b0, 8'h00);
    check({31'h0, rd[FLAG_OVF]}, 32'h1);
    @(posedge hclk);
    ovf_ack <= 1'b1;
    @(posedge hclk);
    ovf_ack <= 1'b0;
    bus(OFF_FLAG, 1'b0, 8'h00);
    check({31'h0, rd[FLAG_OVF]}, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
